// ==== design/jutc_cmd.sv ====
// jog, up/down and three-wire speed command logic
`timescale 1ns/1ps
`include "jutc_defs.svh"
module jutc_cmd #(
   parameter int NTERM   = 11,
   parameter int FW      = 16,
   parameter int UD_STEP = 1
) (
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   input  wire logic [NTERM-1:0]       term_i,
   input  wire logic [NTERM*6-1:0]     terminal_function_assign_i,
   input  wire logic                   forward_run_input_i,
   input  wire logic                   reverse_run_input_i,
   input  wire logic                   key_multi_i,
   input  wire logic                   key_fwd_i,
   input  wire logic                   key_rev_i,
   input  wire logic                   trip_i,
   input  wire logic                   power_fail_i,
   input  wire logic                   at_speed_i,
   input  wire logic [FW-1:0]          max_freq_i,
   input  wire logic [FW-1:0]          normal_freq_i,
   input  wire logic [FW-1:0]          out_freq_i,
   input  wire jutc_pkg::jutc_cfg_t    cfg_i,
   output      jutc_pkg::jutc_ref_t    ref_o,
   output      jutc_pkg::jutc_src_t    src_o,
   output      logic                   keypad_jog_o,
   output      logic                   save_valid_o,
   output      logic [FW-1:0]          saved_freq_o
);
   import jutc_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NIN = NTERM + 6;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] sync1_reg;
   logic [NIN-1:0] sync2_reg;
   assign raw_in = {trip_i, power_fail_i, key_multi_i, key_fwd_i, key_rev_i,
                    forward_run_input_i ^ 1'b0, term_i};
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end
   logic rev_s1_reg;
   logic rev_s2_reg;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rev_s1_reg <= 1'b0;
         rev_s2_reg <= 1'b0;
      end else begin
         rev_s1_reg <= reverse_run_input_i;
         rev_s2_reg <= rev_s1_reg;
      end
   end

   wire [NTERM-1:0] t_s      = sync2_reg[NTERM-1:0];
   wire             fx_s     = sync2_reg[NTERM];
   wire             rx_s     = rev_s2_reg;
   wire             krev_s   = sync2_reg[NTERM+1];
   wire             kfwd_s   = sync2_reg[NTERM+2];
   wire             kmulti_s = sync2_reg[NTERM+3];
   wire             pfail_s  = sync2_reg[NTERM+4];
   wire             trip_s   = sync2_reg[NTERM+5];

   // ----------------------------------------
   // terminal function decode
   // ----------------------------------------
   logic [NTERM-1:0] hit_jog, hit_3w, hit_up, hit_dn, hit_clr, hit_fj, hit_rj;
   logic [NTERM-1:0] asg_3w;
   genvar g;
   generate
      for (g = 0; g < NTERM; g++) begin : g_dec
         wire [5:0] fn = terminal_function_assign_i[g*6 +: 6];
         assign hit_jog[g] = t_s[g] && (fn == `JUTC_FN_JOG);
         assign hit_3w[g]  = t_s[g] && (fn == `JUTC_FN_3WIRE);
         assign asg_3w[g]  = (fn == `JUTC_FN_3WIRE);
         assign hit_up[g]  = t_s[g] && (fn == `JUTC_FN_UP);
         assign hit_dn[g]  = t_s[g] && (fn == `JUTC_FN_DOWN);
         assign hit_clr[g] = t_s[g] && (fn == `JUTC_FN_UD_CLEAR);
         assign hit_fj[g]  = t_s[g] && (fn == `JUTC_FN_FORWARD_JOG_INPUT);
         assign hit_rj[g]  = t_s[g] && (fn == `JUTC_FN_REVERSE_JOG_INPUT);
      end
   endgenerate
   wire jog_t   = |hit_jog;
   wire up_t    = |hit_up;
   wire dn_t    = |hit_dn;
   wire clr_t   = |hit_clr;
   wire fjog_t  = |hit_fj;
   wire rjog_t  = |hit_rj;
   wire three_w = (cfg_i.cmd_source == `JUTC_SRC_TERMINAL) && (|asg_3w);
   wire hold_3w = |hit_3w;

   // ----------------------------------------
   // three-wire latch with pulse qualifier
   // ----------------------------------------
   // a press counts only after it stood the minimum time, so glitches never latch
   localparam int PW = $clog2(`JUTC_MIN_PULSE_CYC + 1);
   localparam logic [PW-1:0] PULSE_CYC = PW'(`JUTC_MIN_PULSE_CYC);
   logic [PW-1:0] fx_cnt_reg, rx_cnt_reg;
   logic          latch_fwd_reg, latch_rev_reg;
   wire fx_ok = fx_s && (fx_cnt_reg >= PULSE_CYC);
   wire rx_ok = rx_s && (rx_cnt_reg >= PULSE_CYC);
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fx_cnt_reg <= '0;
         rx_cnt_reg <= '0;
      end else begin
         fx_cnt_reg <= !fx_s ? '0 : (fx_ok ? fx_cnt_reg : fx_cnt_reg + 1'b1);
         rx_cnt_reg <= !rx_s ? '0 : (rx_ok ? rx_cnt_reg : rx_cnt_reg + 1'b1);
      end
   end
   logic latch_fwd_next, latch_rev_next;
   always_comb begin
      latch_fwd_next = latch_fwd_reg;
      latch_rev_next = latch_rev_reg;
      if (!three_w || !hold_3w) begin
         latch_fwd_next = 1'b0;
         latch_rev_next = 1'b0;
      end else if (fx_ok && rx_ok) begin
         latch_fwd_next = 1'b0;
         latch_rev_next = 1'b0;
      end else if (fx_ok) begin
         latch_fwd_next = 1'b1;
         latch_rev_next = 1'b0;
      end else if (rx_ok) begin
         latch_fwd_next = 1'b0;
         latch_rev_next = 1'b1;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_fwd_reg <= 1'b0;
         latch_rev_reg <= 1'b0;
      end else begin
         latch_fwd_reg <= latch_fwd_next;
         latch_rev_reg <= latch_rev_next;
      end
   end

   // ----------------------------------------
   // run command
   // ----------------------------------------
   wire run_fwd = three_w ? latch_fwd_reg : fx_s;
   wire run_rev = three_w ? latch_rev_reg : rx_s;
   wire both_run = run_fwd && run_rev;
   wire run_cmd  = (run_fwd ^ run_rev) && !trip_s;

   // ----------------------------------------
   // keypad jog arm
   // ----------------------------------------
   logic kmulti_d_reg, kpad_arm_reg;
   wire kpad_ok = (cfg_i.multi_key_sel == `JUTC_MKEY_JOG)
                  && (cfg_i.cmd_source == `JUTC_SRC_KEYPAD);
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kmulti_d_reg <= 1'b0;
         kpad_arm_reg <= 1'b0;
      end else begin
         kmulti_d_reg <= kmulti_s;
         if (!kpad_ok)
            kpad_arm_reg <= 1'b0;
         else if (kmulti_s && !kmulti_d_reg)
            kpad_arm_reg <= !kpad_arm_reg;
      end
   end
   wire kjog = kpad_arm_reg && (kfwd_s ^ krev_s);

   // ----------------------------------------
   // up/down frequency with save
   // ----------------------------------------
   logic [FW-1:0] ud_freq_reg, saved_reg;
   logic          saved_v_reg, run_d_reg, trip_d_reg;
   wire inc = up_t && !dn_t;
   wire dec = dn_t && !up_t;
   wire steady  = !run_cmd || at_speed_i;
   wire run_drop = run_d_reg && !run_cmd && at_speed_i;
   wire trip_rise = trip_s && !trip_d_reg && at_speed_i;
   wire do_save = cfg_i.ud_save_mode && (run_drop || trip_rise || pfail_s);
   wire do_clr  = clr_t && steady;
   wire resume  = run_cmd && !run_d_reg && saved_v_reg;
   wire [FW:0] ud_up = {1'b0, ud_freq_reg} + (FW+1)'(UD_STEP);
   wire [FW-1:0] ud_inc = (ud_up > {1'b0, max_freq_i}) ? max_freq_i : ud_up[FW-1:0];
   wire [FW-1:0] ud_dec = (ud_freq_reg > FW'(UD_STEP)) ? ud_freq_reg - FW'(UD_STEP) : '0;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ud_freq_reg <= '0;
         saved_reg   <= '0;
         saved_v_reg <= 1'b0;
         run_d_reg   <= 1'b0;
         trip_d_reg  <= 1'b0;
      end else begin
         run_d_reg  <= run_cmd;
         trip_d_reg <= trip_s;
         if (resume)
            ud_freq_reg <= saved_reg;
         else if (run_cmd && inc)
            ud_freq_reg <= ud_inc;
         else if (run_cmd && dec)
            ud_freq_reg <= ud_dec;
         if (do_save) begin
            saved_reg   <= out_freq_i;
            saved_v_reg <= 1'b1;
         end else if (do_clr) begin
            saved_reg   <= '0;
            saved_v_reg <= 1'b0;
         end
      end
   end
   wire ud_mode = |(terminal_function_assign_i) && (up_t || dn_t || ud_freq_reg != '0);

   // ----------------------------------------
   // source selection
   // ----------------------------------------
   wire term_jog = fjog_t ^ rjog_t;
   wire run_jog  = jog_t && run_cmd;
   wire any_jog  = term_jog || run_jog || kjog;
   wire [FW-1:0] jog_lo = (cfg_i.jog_freq < `JUTC_JOG_FREQ_MIN) ? FW'(`JUTC_JOG_FREQ_MIN)
                                                              : cfg_i.jog_freq;
   wire [FW-1:0] jog_f  = (jog_lo > max_freq_i) ? max_freq_i : jog_lo;
   wire [15:0] acc_c = (cfg_i.jog_acc > `JUTC_TIME_MAX) ? `JUTC_TIME_MAX : cfg_i.jog_acc;
   wire [15:0] dec_c = (cfg_i.jog_dec > `JUTC_TIME_MAX) ? `JUTC_TIME_MAX : cfg_i.jog_dec;
   jutc_src_t src_next;
   jutc_ref_t ref_next, ref_reg;
   jutc_src_t src_reg;
   always_comb begin
      ref_next = '0;
      src_next = JUTC_SRC_NONE;
      case (1'b1)
         any_jog: begin
            src_next = JUTC_SRC_JOG;
            ref_next.run = 1'b1;
            ref_next.freq = jog_f;
            ref_next.reverse = term_jog ? rjog_t : (kjog ? krev_s : run_rev);
            ref_next.acc_time = acc_c;
            ref_next.dec_time = dec_c;
            ref_next.use_jog_ramp = 1'b1;
         end
         both_run: src_next = JUTC_SRC_STOP;
         run_cmd: begin
            src_next = ud_mode ? JUTC_SRC_UPDOWN : JUTC_SRC_NORMAL;
            ref_next.run = 1'b1;
            ref_next.reverse = run_rev;
            ref_next.freq = ud_mode ? ud_freq_reg : normal_freq_i;
         end
         default: src_next = JUTC_SRC_NONE;
      endcase
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_reg <= '0;
         src_reg <= JUTC_SRC_NONE;
      end else begin
         ref_reg <= ref_next;
         src_reg <= src_next;
      end
   end
   assign ref_o        = ref_reg;
   assign src_o        = src_reg;
   assign keypad_jog_o = kpad_arm_reg;
   assign save_valid_o = saved_v_reg;
   assign saved_freq_o = saved_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_jog_freq;
      @(posedge clock_i) disable iff (!rst_n_i)
      any_jog |=> (ref_o.freq == $past(jog_f)) && ref_o.run;
   endproperty
   a_jog_freq: assert property (p_jog_freq) else $error("jog freq not applied");
   property p_jog_min;
      @(posedge clock_i) disable iff (!rst_n_i)
      (max_freq_i >= FW'(`JUTC_JOG_FREQ_MIN)) |-> jog_f >= FW'(`JUTC_JOG_FREQ_MIN);
   endproperty
   a_jog_min: assert property (p_jog_min) else $error("jog freq under minimum");
   property p_jog_prio;
      @(posedge clock_i) disable iff (!rst_n_i)
      (any_jog && run_cmd) |=> src_o == JUTC_SRC_JOG;
   endproperty
   a_jog_prio: assert property (p_jog_prio) else $error("jog lost priority");
   property p_jog_ramp;
      @(posedge clock_i) disable iff (!rst_n_i)
      any_jog |=> ref_o.use_jog_ramp && ref_o.acc_time <= `JUTC_TIME_MAX;
   endproperty
   a_jog_ramp: assert property (p_jog_ramp) else $error("jog ramp wrong");
   property p_term_jog;
      @(posedge clock_i) disable iff (!rst_n_i)
      (term_jog && !run_cmd) |=> ref_o.run;
   endproperty
   a_term_jog: assert property (p_term_jog) else $error("terminal jog not run");
   property p_both_stop;
      @(posedge clock_i) disable iff (!rst_n_i)
      (both_run && !any_jog) |=> !ref_o.run;
   endproperty
   a_both_stop: assert property (p_both_stop) else $error("fwd+rev did not stop");
   property p_hold;
      @(posedge clock_i) disable iff (!rst_n_i)
      (up_t && dn_t && !resume) |=> $stable(ud_freq_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("up+down changed freq");
   property p_3w_drop;
      @(posedge clock_i) disable iff (!rst_n_i)
      (three_w && !hold_3w) |=> !latch_fwd_reg && !latch_rev_reg;
   endproperty
   a_3w_drop: assert property (p_3w_drop) else $error("latch kept after stop");
   property p_save;
      @(posedge clock_i) disable iff (!rst_n_i)
      do_save |=> saved_v_reg;
   endproperty
   a_save: assert property (p_save) else $error("save missed");
   c_jog:    cover property (@(posedge clock_i) src_o == JUTC_SRC_JOG);
   c_latch:  cover property (@(posedge clock_i) latch_fwd_reg);
   c_save:   cover property (@(posedge clock_i) do_save);
   c_kpad:   cover property (@(posedge clock_i) kjog);
endmodule : jutc_cmd

// ==== design/jutc_defs.svh ====
// constants for the jog, up/down and three-wire speed command block
`ifndef JUTC_DEFS_SVH
`define JUTC_DEFS_SVH
`define JUTC_FN_JOG        6'h06
`define JUTC_FN_3WIRE      6'h0E
`define JUTC_FN_UP         6'h11
`define JUTC_FN_DOWN       6'h12
`define JUTC_FN_UD_CLEAR   6'h14
`define JUTC_FN_FORWARD_JOG_INPUT    6'h2E
`define JUTC_FN_REVERSE_JOG_INPUT    6'h2F
`define JUTC_SRC_KEYPAD    3'h0
`define JUTC_SRC_TERMINAL  3'h1
`define JUTC_MKEY_JOG      2'h1
`define JUTC_JOG_FREQ_RST  16'h03E8
`define JUTC_JOG_FREQ_MIN  16'h0032
`define JUTC_JOG_ACC_RST   16'h07D0
`define JUTC_JOG_DEC_RST   16'h0BB8
`define JUTC_TIME_MAX      16'hEA60
`define JUTC_CLK_MHZ       200
`define JUTC_MIN_PULSE_US  1000
`define JUTC_MIN_PULSE_CYC (`JUTC_CLK_MHZ * `JUTC_MIN_PULSE_US)
`endif

// ==== design/jutc_pkg.sv ====
// types shared by the speed command block
package jutc_pkg;
   typedef enum logic [2:0] {
      JUTC_SRC_NONE,
      JUTC_SRC_NORMAL,
      JUTC_SRC_UPDOWN,
      JUTC_SRC_JOG,
      JUTC_SRC_STOP
   } jutc_src_t;

   typedef struct packed {
      logic [15:0] jog_freq;
      logic [15:0] jog_acc;
      logic [15:0] jog_dec;
      logic [2:0]  cmd_source;
      logic [1:0]  multi_key_sel;
      logic        ud_save_mode;
   } jutc_cfg_t;

   typedef struct packed {
      logic        run;
      logic        reverse;
      logic [15:0] freq;
      logic [15:0] acc_time;
      logic [15:0] dec_time;
      logic        use_jog_ramp;
   } jutc_ref_t;
endpackage : jutc_pkg

// ==== sim/jutc_panel_model.sv ====
// push-button, limit-switch and keypad model driving the speed command block
`timescale 1ns/1ps
module jutc_panel_model (
   input  wire logic        clock_i,
   output      logic [10:0] term_o,
   output      logic        fwd_o,
   output      logic        rev_o,
   output      logic [2:0]  keys_o
);
   initial begin
      term_o = 11'h000;
      fwd_o  = 1'b0;
      rev_o  = 1'b0;
      keys_o = 3'h0;
   end

   // contacts move just after an edge and then stay put for at least a
   // few cycles; a three-wire terminal is wired only in the last scenario, where
   // a forward press far under the minimum time is offered to the latch
   task automatic set_pins(input logic [10:0] t, input logic f, input logic r,
                           input logic [2:0] k, input int hold);
      @(posedge clock_i);
      term_o <= t;
      fwd_o  <= f;
      rev_o  <= r;
      keys_o <= k;
      repeat (hold) @(posedge clock_i);
   endtask : set_pins
endmodule : jutc_panel_model

// ==== sim/jutc_cmd_test.sv ====
// self-checking bench for the jog, up/down and three-wire command block
`timescale 1ns/1ps
`include "jutc_defs.svh"
module jutc_cmd_test;
   import jutc_pkg::*;
   logic        clock_i;
   logic        rst_n_i;
   logic        fwd, rev, at_speed;
   logic [10:0] term;
   logic [2:0]  keys;
   logic [65:0] fa;
   logic [5:0]  fn_p1;
   logic [15:0] normf, outf, f1, f2, jf, ja, jd;
   jutc_cfg_t   cfg;
   jutc_ref_t   rf;
   jutc_src_t   src;
   logic        kj, sv;
   logic [15:0] sf;
   int          miscompares = 0;
   int          samples_checked = 0;
   int unsigned seed_word;

   // ----------------------------------------------------------------
   // clock, reset, wiring
   // ----------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   assign fa = {24'h000000, `JUTC_FN_REVERSE_JOG_INPUT, `JUTC_FN_FORWARD_JOG_INPUT, `JUTC_FN_UD_CLEAR,
                `JUTC_FN_DOWN, `JUTC_FN_UP, fn_p1, `JUTC_FN_JOG};

   // ramp stand-in: output frequency follows the reference one cycle late
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         outf <= 16'h0000;
      end else begin
         outf <= rf.freq;
      end
   end
   assign at_speed = (outf == rf.freq);

   jutc_panel_model jutc_panel_model_inst (
      .clock_i (clock_i),
      .term_o  (term),
      .fwd_o   (fwd),
      .rev_o   (rev),
      .keys_o  (keys)
   );

   jutc_cmd jutc_cmd_inst (
      .clock_i                    (clock_i),
      .rst_n_i                    (rst_n_i),
      .term_i                     (term),
      .terminal_function_assign_i (fa),
      .forward_run_input_i        (fwd),
      .reverse_run_input_i        (rev),
      .key_multi_i                (keys[0]),
      .key_fwd_i                  (keys[1]),
      .key_rev_i                  (keys[2]),
      .trip_i                     (1'b0),
      .power_fail_i               (1'b0),
      .at_speed_i                 (at_speed),
      .max_freq_i                 (16'h1000),
      .normal_freq_i              (normf),
      .out_freq_i                 (outf),
      .cfg_i                      (cfg),
      .ref_o                      (rf),
      .src_o                      (src),
      .keypad_jog_o               (kj),
      .save_valid_o               (sv),
      .saved_freq_o               (sf)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] jog_exp(input logic [15:0] f);
      if (f < `JUTC_JOG_FREQ_MIN) return `JUTC_JOG_FREQ_MIN;
      if (f > 16'h1000) return 16'h1000;
      return f;
   endfunction : jog_exp

   function automatic logic [15:0] t_exp(input logic [15:0] t);
      return (t > `JUTC_TIME_MAX) ? `JUTC_TIME_MAX : t;
   endfunction : t_exp

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic pins(input logic [10:0] t, input logic f, input logic r, input logic [2:0] k);
      jutc_panel_model_inst.set_pins(t, f, r, k, 1);
   endtask : pins

   // bounded wait for the selected source, then a little settling time
   task automatic settle(input jutc_src_t s);
      int n;
      n = 0;
      repeat (3) @(posedge clock_i);
      while (src !== s && n < 20) begin
         @(posedge clock_i);
         n++;
      end
      if (n == 20) begin
         chk("source", src, s);
         give_verdict();
      end
      repeat (2) @(posedge clock_i);
      #1;
   endtask : settle

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      seed_word = $urandom(32'h4ADA);
      rst_n_i = 1'b0;
      fn_p1 = 6'h00;
      normf = 16'h0400;
      cfg = '{`JUTC_JOG_FREQ_RST, `JUTC_JOG_ACC_RST, `JUTC_JOG_DEC_RST,
              `JUTC_SRC_TERMINAL, 2'h0, 1'b1};
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      chk("reset ref", rf, '0);
      chk("reset source", src, JUTC_SRC_NONE);
      // jog with run active: default, corners, then random settings
      for (int i = 0; i < 8; i++) begin
         jf = (i == 0) ? `JUTC_JOG_FREQ_RST : (i == 1) ? 16'h0031 :
              (i == 2) ? `JUTC_JOG_FREQ_MIN : (i == 3) ? 16'h1001 : 16'($urandom_range(16'h1400));
         ja = (i == 0) ? `JUTC_JOG_ACC_RST : (i == 1) ? 16'hEA61 : 16'($urandom_range(16'hFFFF));
         jd = (i == 0) ? `JUTC_JOG_DEC_RST : (i == 2) ? `JUTC_TIME_MAX : 16'($urandom);
         @(posedge clock_i);
         cfg.jog_freq <= jf;
         cfg.jog_acc  <= ja;
         cfg.jog_dec  <= jd;
         normf        <= 16'($urandom_range(16'h0FFF));
         pins(11'h000, 1'b1, 1'b0, 3'h0);
         settle(JUTC_SRC_NORMAL);
         chk("normal freq", rf.freq, normf);
         pins(11'h001, 1'b1, 1'b0, 3'h0);
         settle(JUTC_SRC_JOG);
         chk("jog freq", rf.freq, jog_exp(jf));
         chk("jog acc", rf.acc_time, t_exp(ja));
         chk("jog dec", rf.dec_time, t_exp(jd));
         chk("jog ramp", {rf.use_jog_ramp, rf.run}, 2'h3);
      end
      // terminal-only jog, then a run command on top of it
      pins(11'h020, 1'b0, 1'b0, 3'h0);
      settle(JUTC_SRC_JOG);
      chk("forward_jog_input", {rf.run, rf.reverse}, 2'h2);
      pins(11'h020, 1'b1, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("jog kept", {src, rf.freq}, {JUTC_SRC_JOG, jog_exp(jf)});
      pins(11'h040, 1'b0, 1'b0, 3'h0);
      settle(JUTC_SRC_JOG);
      chk("reverse_jog_input", {rf.run, rf.reverse}, 2'h3);
      pins(11'h000, 1'b1, 1'b1, 3'h0);
      settle(JUTC_SRC_STOP);
      chk("both run stop", rf.run, 1'b0);
      // up/down stepping, save and clear
      pins(11'h004, 1'b1, 1'b0, 3'h0);
      settle(JUTC_SRC_UPDOWN);
      f1 = rf.freq;
      repeat (30) @(posedge clock_i);
      chk("up raises", rf.freq > f1, 1'b1);
      pins(11'h005, 1'b1, 1'b0, 3'h0);
      settle(JUTC_SRC_JOG);
      pins(11'h000, 1'b1, 1'b0, 3'h0);
      settle(JUTC_SRC_UPDOWN);
      f1 = rf.freq;
      repeat (20) @(posedge clock_i);
      chk("up release holds", rf.freq, f1);
      pins(11'h008, 1'b1, 1'b0, 3'h0);
      repeat (12) @(posedge clock_i);
      chk("down lowers", rf.freq < f1, 1'b1);
      pins(11'h00C, 1'b1, 1'b0, 3'h0);
      repeat (5) @(posedge clock_i);
      f1 = rf.freq;
      repeat (20) @(posedge clock_i);
      chk("up and down hold", rf.freq, f1);
      pins(11'h000, 1'b1, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      f2 = rf.freq;
      chk("down release holds", f2, f1);
      pins(11'h000, 1'b0, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("saved", {sv, sf}, {1'b1, f2});
      pins(11'h000, 1'b1, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("resume saved", rf.freq, f2);
      pins(11'h010, 1'b0, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("save cleared", sv, 1'b0);
      // keypad jog: arming needs multi-key selection 1 and keypad source
      @(posedge clock_i);
      cfg.cmd_source <= `JUTC_SRC_KEYPAD;
      jutc_panel_model_inst.set_pins(11'h000, 1'b0, 1'b0, 3'h1, 5);
      pins(11'h000, 1'b0, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("no arm", kj, 1'b0);
      @(posedge clock_i);
      cfg.multi_key_sel <= `JUTC_MKEY_JOG;
      jutc_panel_model_inst.set_pins(11'h000, 1'b0, 1'b0, 3'h1, 5);
      pins(11'h000, 1'b0, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      chk("armed", kj, 1'b1);
      for (int k = 0; k < 2; k++) begin
         pins(11'h000, 1'b0, 1'b0, (k == 0) ? 3'h2 : 3'h4);
         settle(JUTC_SRC_JOG);
         chk("key jog", {rf.run, rf.reverse, rf.freq}, {1'b1, k[0], jog_exp(jf)});
         pins(11'h000, 1'b0, 1'b0, 3'h0);
         repeat (6) @(posedge clock_i);
         chk("key released", rf.run, 1'b0);
      end
      // three-wire: a press far under the minimum time must not latch a run
      @(posedge clock_i);
      cfg.cmd_source <= `JUTC_SRC_TERMINAL;
      fn_p1          <= `JUTC_FN_3WIRE;
      pins(11'h002, 1'b1, 1'b0, 3'h0);
      repeat (20) @(posedge clock_i);
      #1;
      chk("short press", {src, rf.run}, {JUTC_SRC_NONE, 1'b0});
      // dropping the hold terminal keeps the latch clear and the drive stopped
      pins(11'h000, 1'b0, 1'b0, 3'h0);
      repeat (6) @(posedge clock_i);
      #1;
      chk("hold released", {src, rf.run}, {JUTC_SRC_NONE, 1'b0});
      give_verdict();
   end
endmodule : jutc_cmd_test
